//--- hdl/msc_pkg.sv
// constants and types shared by both ends of the motion search sequence link
// assumes one clock at the pixel rate on both ends
// Contract
// (RQ1) latch both geometry selects on block start
// (RQ2) controller sets tall select per block height
// (RQ3) decode selects into four block sizes
// (RQ4) rectangular mode: strobe every block sequence
// (RQ5) rectangular widths vary, multiples of four
// (RQ6) square mode: strobe only with initialization
// (RQ7) square pipeline: single strobe at start
// (RQ8) controller holds reset low before initialization
// (RQ9) vector ready 38 or 46 after last
// (RQ10) latency 32n+38 or 64n+46 cycles total
// (RQ11) one latency pulse per block start
// (RQ12) latency pulse coincides with vector ready
// (RQ13) freeze halts device without losing state
// (RQ14) last block of row: right edge pattern
// (RQ15) first block of row: left edge pattern; a row of one block gets the right pattern
// (RQ16) search columns lead reference by eight
// (RQ17) 16x16: half-column selects two bands
// (RQ18) sub-window result after 46th init cycle
// (RQ19) clamp -16 component to -15
// (RQ20) latch edge limits at sequence start
// (RQ21) right edge: horizontal component not positive
// (RQ22) left edge: horizontal component not negative
// (RQ23) link inputs sampled on edge, ignored frozen
package msc_pkg;
   // ======================================
   // types
   typedef enum logic [1:0] {SIZE_8X8, SIZE_8X4N, SIZE_16X16, SIZE_16X4N} msc_size_type;
   typedef enum logic [1:0] {CTL_IDLE, CTL_RESET, CTL_RUN} msc_ctl_state_type;
   // ======================================
   // timing and geometry
   localparam int DELAY_SHORT = 38;
   localparam int DELAY_TALL = 46;
   localparam int UNIT_SHORT = 32;
   localparam int UNIT_TALL = 64;
   localparam int SQ_LEN_SHORT = 64;
   localparam int SQ_LEN_TALL = 256;
   localparam int HEIGHT_SHORT = 8;
   localparam int HEIGHT_TALL = 16;
   localparam int COLS_PER_UNIT = 4;
   localparam int HALF_COL_BIT = 3;
   localparam int SEARCH_LEAD = 8;
   localparam int CNT_W = 14;
   localparam int SLOT_W = 6;
   localparam int CLOCK_HZ = 10000000;
   // ======================================
   // vector ranges and edge patterns
   localparam logic signed [3:0] VEC_LO = 4'sh8;
   localparam logic signed [3:0] VEC_HI = 4'sh7;
   localparam logic signed [3:0] VEC_ZERO = 4'sh0;
   localparam logic signed [4:0] RAW_MIN = 5'sh10;
   localparam logic signed [4:0] RAW_CLAMP = 5'sh11;
   localparam logic [3:0] EDGE_RIGHT_ONLY = 4'h2;
   localparam logic [3:0] EDGE_LEFT_ONLY = 4'h8;
   localparam int EDGE_TOP = 0;
   localparam int EDGE_RIGHT = 1;
   localparam int EDGE_BOTTOM = 2;
   localparam int EDGE_LEFT = 3;
   // ======================================
   // controller register map (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_EDGE = 8'h04;
   localparam logic [7:0] REG_UNITS = 8'h08;
   localparam logic [7:0] REG_ROW = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_CLAMP = 8'h14;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_TALL = 1;
   localparam int CTRL_RECT = 2;
   localparam int CTRL_FREEZE = 3;
   localparam int CTRL_AUTO_ROW = 4;
   localparam logic [4:0] CTRL_RESET_VAL = 5'h00;
   localparam logic [7:0] UNITS_RESET_VAL = 8'h01;
   localparam logic [7:0] ROW_RESET_VAL = 8'h01;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // ======================================
   // geometry decode
   function automatic msc_size_type msc_decode(input logic tall, input logic sq_n);
      msc_size_type s;
      s = msc_size_type'({tall, sq_n}); // [RQ3]
      return s;
   endfunction : msc_decode

   function automatic logic [CNT_W-1:0] msc_unit_len(input logic tall);
      logic [CNT_W-1:0] u;
      u = tall ? CNT_W'(UNIT_TALL) : CNT_W'(UNIT_SHORT);
      return u;
   endfunction : msc_unit_len
endpackage : msc_pkg

//--- hdl/msc_link_if.sv
// link between the motion search device and its system controller
// assumes both ends share sys_clk_i
`timescale 1ns/1ns
interface msc_link_if;
   logic chip_reset_n;
   logic block_start_strobe_n;
   logic tall_block_select;
   logic square_select_n;
   logic top_edge_limit;
   logic right_edge_limit;
   logic bottom_edge_limit;
   logic left_edge_limit;
   logic freeze;
   logic vector_ready_strobe_n;
   logic latency_strobe_n;
   modport device (input chip_reset_n, block_start_strobe_n, tall_block_select,
      square_select_n, top_edge_limit, right_edge_limit, bottom_edge_limit,
      left_edge_limit, freeze, output vector_ready_strobe_n, latency_strobe_n);
   modport ctrl (output chip_reset_n, block_start_strobe_n, tall_block_select,
      square_select_n, top_edge_limit, right_edge_limit, bottom_edge_limit,
      left_edge_limit, freeze, input vector_ready_strobe_n, latency_strobe_n);
endinterface : msc_link_if

//--- hdl/msc_device.sv
// sequence control of the motion search device
// assumes link inputs come from logic on sys_clk_i
`timescale 1ns/1ns
module msc_device #(
   parameter int SLOTS = 2
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   msc_link_if.device link,
   output msc_pkg::msc_size_type block_size_o,
   output logic signed [3:0] h_lo_o,
   output logic signed [3:0] h_hi_o,
   output logic signed [3:0] v_lo_o,
   output logic signed [3:0] v_hi_o,
   output logic upper_bands_o,
   output logic width_error_o
);
   import msc_pkg::*;

   // ======================================
   // state
   logic started, next_started;
   logic tall, next_tall;
   logic sq_n, next_sq_n;
   logic [CNT_W-1:0] seq_cnt, next_seq_cnt;
   logic seq_strobed, next_seq_strobed;
   logic [SLOT_W-1:0] slot_cnt [SLOTS];
   logic [SLOT_W-1:0] next_slot_cnt [SLOTS];
   logic slot_lat [SLOTS];
   logic next_slot_lat [SLOTS];
   logic vr_n, next_vr_n;
   logic lat_n, next_lat_n;
   msc_size_type size, next_size;
   logic signed [3:0] h_lo, next_h_lo, h_hi, next_h_hi;
   logic signed [3:0] v_lo, next_v_lo, v_hi, next_v_hi;
   logic upper, next_upper;
   logic werr, next_werr;

   // ======================================
   // next state
   always_comb
   begin
      logic strobe;
      logic wrap;
      logic start;
      logic placed;
      logic fire_vr;
      logic fire_lat;
      logic [CNT_W-1:0] seq_len;
      logic [CNT_W-1:0] ended_len;
      logic [SLOT_W-1:0] delay;
      strobe = 1'b0;
      wrap = 1'b0;
      start = 1'b0;
      placed = 1'b0;
      fire_vr = 1'b0;
      fire_lat = 1'b0;
      seq_len = '0;
      ended_len = '0;
      delay = '0;
      next_started = started;
      next_tall = tall;
      next_sq_n = sq_n;
      next_seq_cnt = seq_cnt;
      next_seq_strobed = seq_strobed;
      next_slot_cnt = slot_cnt;
      next_slot_lat = slot_lat;
      next_vr_n = 1'b1;
      next_lat_n = 1'b1;
      next_size = size;
      next_h_lo = h_lo;
      next_h_hi = h_hi;
      next_v_lo = v_lo;
      next_v_hi = v_hi;
      next_upper = upper;
      next_werr = werr;
      if (link.freeze)
      begin
         // hold everything, strobes keep their level [RQ13] [RQ23]
         next_vr_n = vr_n;
         next_lat_n = lat_n;
      end
      else if (!link.chip_reset_n)
      begin
         next_started = 1'b0;
         next_seq_cnt = '0;
         next_seq_strobed = 1'b0;
         for (int i = 0; i < SLOTS; i++)
         begin
            next_slot_cnt[i] = '0;
            next_slot_lat[i] = 1'b0;
         end
         next_werr = 1'b0;
      end
      else
      begin
         seq_len = sq_n ? '0 : (tall ? CNT_W'(SQ_LEN_TALL) : CNT_W'(SQ_LEN_SHORT));
         strobe = !link.block_start_strobe_n; // [RQ23]
         wrap = started && !sq_n && (seq_cnt == seq_len - CNT_W'(1)); // [RQ6] [RQ7]
         start = strobe || wrap;
         // result timers, one pulse per ended sequence
         for (int i = 0; i < SLOTS; i++)
         begin
            if (slot_cnt[i] != '0)
            begin
               next_slot_cnt[i] = slot_cnt[i] - SLOT_W'(1);
               if (slot_cnt[i] == SLOT_W'(1))
               begin
                  fire_vr = 1'b1;
                  fire_lat = fire_lat | slot_lat[i];
               end
            end
         end
         next_vr_n = !fire_vr; // [RQ9]
         next_lat_n = !fire_lat; // [RQ11] [RQ12]
         if (start && started)
         begin
            // timer ends one edge early so the pulse stands tlat after strobe [RQ9] [RQ10] [RQ18]
            delay = tall ? SLOT_W'(DELAY_TALL - 1) : SLOT_W'(DELAY_SHORT - 1);
            for (int i = 0; i < SLOTS; i++)
            begin
               if (!placed && (slot_cnt[i] == '0 || slot_cnt[i] == SLOT_W'(1)))
               begin
                  next_slot_cnt[i] = delay;
                  next_slot_lat[i] = seq_strobed;
                  placed = 1'b1;
               end
            end
            ended_len = seq_cnt + CNT_W'(1);
            if (sq_n)
            begin
               // any multiple of four columns accepted [RQ5]
               next_werr = (ended_len & (msc_unit_len(tall) - CNT_W'(1))) != '0;
            end
         end
         if (start)
         begin
            next_started = 1'b1;
            next_seq_cnt = '0;
            next_seq_strobed = strobe;
            if (strobe)
            begin
               next_tall = link.tall_block_select; // [RQ1]
               next_sq_n = link.square_select_n; // [RQ1]
               next_size = msc_decode(link.tall_block_select, link.square_select_n); // [RQ3]
            end
            // edge limits bound the window loaded now [RQ20]
            next_h_lo = link.left_edge_limit ? VEC_ZERO : VEC_LO; // [RQ22]
            next_h_hi = link.right_edge_limit ? VEC_ZERO : VEC_HI; // [RQ21]
            next_v_lo = link.top_edge_limit ? VEC_ZERO : VEC_LO;
            next_v_hi = link.bottom_edge_limit ? VEC_ZERO : VEC_HI;
         end
         else if (started)
         begin
            next_seq_cnt = seq_cnt + CNT_W'(1);
         end
         // upper half of column pairs with bands a and b [RQ17]
         next_upper = (next_size == SIZE_16X16) && next_seq_cnt[HALF_COL_BIT];
      end
   end

   // ======================================
   // registers
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         started <= 1'b0;
         tall <= 1'b0;
         sq_n <= 1'b0;
         seq_cnt <= '0;
         seq_strobed <= 1'b0;
         for (int i = 0; i < SLOTS; i++)
         begin
            slot_cnt[i] <= '0;
            slot_lat[i] <= 1'b0;
         end
         vr_n <= 1'b1;
         lat_n <= 1'b1;
         size <= SIZE_8X8;
         h_lo <= VEC_LO;
         h_hi <= VEC_HI;
         v_lo <= VEC_LO;
         v_hi <= VEC_HI;
         upper <= 1'b0;
         werr <= 1'b0;
      end
      else
      begin
         started <= next_started;
         tall <= next_tall;
         sq_n <= next_sq_n;
         seq_cnt <= next_seq_cnt;
         seq_strobed <= next_seq_strobed;
         slot_cnt <= next_slot_cnt;
         slot_lat <= next_slot_lat;
         vr_n <= next_vr_n;
         lat_n <= next_lat_n;
         size <= next_size;
         h_lo <= next_h_lo;
         h_hi <= next_h_hi;
         v_lo <= next_v_lo;
         v_hi <= next_v_hi;
         upper <= next_upper;
         werr <= next_werr;
      end
   end

   // ======================================
   // outputs
   assign link.vector_ready_strobe_n = vr_n;
   assign link.latency_strobe_n = lat_n;
   assign block_size_o = size;
   assign h_lo_o = h_lo;
   assign h_hi_o = h_hi;
   assign v_lo_o = v_lo;
   assign v_hi_o = v_hi;
   assign upper_bands_o = upper;
   assign width_error_o = werr;
endmodule : msc_device

//--- hdl/msc_ctrl.sv
// system controller: ahb-lite registers, strobe and edge sequencing
// assumes the device end of msc_link_if shares sys_clk_i
`timescale 1ns/1ns
module msc_ctrl #(
   parameter int RESET_CYCLES = 1
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic hsel_i,
   input wire logic [7:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [15:0] search_col_o,
   msc_link_if.ctrl link
);
   import msc_pkg::*;

   // ======================================
   // state
   msc_ctl_state_type state, next_state;
   logic [4:0] ctrl, next_ctrl;
   logic [3:0] edge_reg, next_edge_reg;
   logic [7:0] units, next_units;
   logic [7:0] row_len, next_row_len;
   logic signed [4:0] raw_vec, next_raw_vec;
   logic [7:0] rst_cnt, next_rst_cnt;
   logic [CNT_W-1:0] seq_cnt, next_seq_cnt;
   logic [7:0] blk, next_blk;
   logic first, next_first;
   logic [7:0] vr_count, next_vr_count;
   logic [7:0] lat_count, next_lat_count;
   logic wr_pend, next_wr_pend;
   logic [7:0] wr_addr, next_wr_addr;
   logic [31:0] rdata, next_rdata;
   logic chip_rst_n, next_chip_rst_n;
   logic bs_n, next_bs_n;
   logic [3:0] edges, next_edges;
   logic [15:0] scol, next_scol;

   // ======================================
   // next state
   always_comb
   begin
      logic take;
      logic rect;
      logic signed [4:0] clamped;
      logic [CNT_W-1:0] seq_len;
      logic [15:0] width;
      take = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
      rect = ctrl[CTRL_RECT];
      clamped = (raw_vec == RAW_MIN) ? RAW_CLAMP : raw_vec; // [RQ19]
      width = rect ? 16'(COLS_PER_UNIT * units) :
         (ctrl[CTRL_TALL] ? 16'(HEIGHT_TALL) : 16'(HEIGHT_SHORT));
      seq_len = rect ? CNT_W'(msc_unit_len(ctrl[CTRL_TALL]) * units) :
         (ctrl[CTRL_TALL] ? CNT_W'(SQ_LEN_TALL) : CNT_W'(SQ_LEN_SHORT));
      next_state = state;
      next_ctrl = ctrl;
      next_edge_reg = edge_reg;
      next_units = units;
      next_row_len = row_len;
      next_raw_vec = raw_vec;
      next_rst_cnt = rst_cnt;
      next_seq_cnt = seq_cnt;
      next_blk = blk;
      next_first = first;
      next_vr_count = vr_count + 8'(!link.vector_ready_strobe_n);
      next_lat_count = lat_count + 8'(!link.latency_strobe_n);
      next_wr_pend = take && hwrite_i;
      next_wr_addr = haddr_i;
      next_rdata = rdata;
      next_chip_rst_n = 1'b1;
      next_bs_n = 1'b1;
      next_edges = edges;
      next_scol = scol;
      // register writes land in the data phase
      if (wr_pend)
      begin
         if (wr_addr == REG_CTRL)
            next_ctrl = hwdata_i[4:0];
         else if (wr_addr == REG_EDGE)
            next_edge_reg = hwdata_i[3:0];
         else if (wr_addr == REG_UNITS)
            next_units = hwdata_i[7:0];
         else if (wr_addr == REG_ROW)
            next_row_len = hwdata_i[7:0];
         else if (wr_addr == REG_CLAMP)
            next_raw_vec = hwdata_i[4:0];
      end
      if (take && !hwrite_i)
      begin
         if (haddr_i == REG_CTRL)
            next_rdata = {27'h0000000, ctrl};
         else if (haddr_i == REG_EDGE)
            next_rdata = {28'h0000000, edge_reg};
         else if (haddr_i == REG_UNITS)
            next_rdata = {24'h000000, units};
         else if (haddr_i == REG_ROW)
            next_rdata = {24'h000000, row_len};
         else if (haddr_i == REG_STATUS)
            next_rdata = {14'h0000, state, lat_count, vr_count};
         else if (haddr_i == REG_CLAMP)
            next_rdata = {27'h0000000, clamped};
         else
            next_rdata = 32'h00000000;
      end
      case (state)
         CTL_IDLE:
         begin
            if (ctrl[CTRL_RUN])
            begin
               next_state = CTL_RESET;
               next_rst_cnt = 8'(RESET_CYCLES);
               next_chip_rst_n = 1'b0; // [RQ8]
            end
         end
         CTL_RESET:
         begin
            next_chip_rst_n = 1'b0; // [RQ8]
            next_rst_cnt = rst_cnt - 8'h01;
            if (rst_cnt <= 8'h01)
            begin
               next_chip_rst_n = 1'b1;
               next_state = CTL_RUN;
               next_seq_cnt = '0;
               next_blk = '0;
               next_first = 1'b1;
            end
         end
         CTL_RUN:
         begin
            if (!ctrl[CTRL_RUN])
               next_state = CTL_IDLE;
            else if (!ctrl[CTRL_FREEZE])
            begin
               if (seq_cnt == '0)
               begin
                  // strobe every rectangular block, square only at init
                  next_bs_n = !(rect || first); // [RQ4] [RQ6] [RQ7]
                  next_first = 1'b0;
                  if (ctrl[CTRL_AUTO_ROW] && blk == row_len - 8'h01)
                     next_edges = EDGE_RIGHT_ONLY; // [RQ14]
                  else if (ctrl[CTRL_AUTO_ROW] && blk == 8'h00)
                     next_edges = EDGE_LEFT_ONLY; // [RQ15]
                  else
                     next_edges = edge_reg;
                  next_scol = 16'(blk * width) + 16'(SEARCH_LEAD); // [RQ16]
               end
               if (seq_cnt >= seq_len - CNT_W'(1))
               begin
                  next_seq_cnt = '0;
                  next_blk = (blk >= row_len - 8'h01) ? 8'h00 : blk + 8'h01;
               end
               else
                  next_seq_cnt = seq_cnt + CNT_W'(1);
            end
         end
         default:
            next_state = CTL_IDLE;
      endcase
   end

   // ======================================
   // registers
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state <= CTL_IDLE;
         ctrl <= CTRL_RESET_VAL;
         edge_reg <= 4'h0;
         units <= UNITS_RESET_VAL;
         row_len <= ROW_RESET_VAL;
         raw_vec <= 5'h00;
         rst_cnt <= 8'h00;
         seq_cnt <= '0;
         blk <= 8'h00;
         first <= 1'b0;
         vr_count <= 8'h00;
         lat_count <= 8'h00;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         rdata <= 32'h00000000;
         chip_rst_n <= 1'b1;
         bs_n <= 1'b1;
         edges <= 4'h0;
         scol <= 16'h0000;
      end
      else
      begin
         state <= next_state;
         ctrl <= next_ctrl;
         edge_reg <= next_edge_reg;
         units <= next_units;
         row_len <= next_row_len;
         raw_vec <= next_raw_vec;
         rst_cnt <= next_rst_cnt;
         seq_cnt <= next_seq_cnt;
         blk <= next_blk;
         first <= next_first;
         vr_count <= next_vr_count;
         lat_count <= next_lat_count;
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         rdata <= next_rdata;
         chip_rst_n <= next_chip_rst_n;
         bs_n <= next_bs_n;
         edges <= next_edges;
         scol <= next_scol;
      end
   end

   // ======================================
   // outputs
   assign hrdata_o = rdata;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign search_col_o = scol;
   assign link.chip_reset_n = chip_rst_n;
   assign link.block_start_strobe_n = bs_n;
   assign link.tall_block_select = ctrl[CTRL_TALL]; // [RQ2]
   assign link.square_select_n = ctrl[CTRL_RECT];
   assign link.freeze = ctrl[CTRL_FREEZE];
   assign link.top_edge_limit = edges[EDGE_TOP];
   assign link.right_edge_limit = edges[EDGE_RIGHT];
   assign link.bottom_edge_limit = edges[EDGE_BOTTOM];
   assign link.left_edge_limit = edges[EDGE_LEFT];
endmodule : msc_ctrl

//--- verification/msc_monitor.sv
// link checker for controller and device
// assumes the testbench instantiates it beside the shared link
`timescale 1ns/1ns
module msc_monitor (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic chip_reset_n,
   input wire logic block_start_strobe_n,
   input wire logic tall_block_select,
   input wire logic square_select_n,
   input wire logic freeze,
   input wire logic vector_ready_strobe_n,
   input wire logic latency_strobe_n
);
   logic reset_seen;
   logic next_reset_seen;
   // ======================================
   // helper: link reset seen since power-up
   always_comb
   begin
      next_reset_seen = reset_seen | ~chip_reset_n;
   end
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         reset_seen <= 1'b0;
      end
      else
      begin
         reset_seen <= next_reset_seen;
      end
   end
   // ======================================
   // properties
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence short_start;
      !block_start_strobe_n && !freeze && !tall_block_select && !square_select_n;
   endsequence
   sequence tall_start;
      !block_start_strobe_n && !freeze && tall_block_select && !square_select_n;
   endsequence
   AST_LAT_WITH_VEC: assert property (!latency_strobe_n |-> !vector_ready_strobe_n)
      else $error("latency strobe without vector strobe");
   AST_LAT_ONE_CYCLE: assert property (!latency_strobe_n && !freeze |=> latency_strobe_n)
      else $error("latency strobe longer than one cycle");
   AST_VEC_ONE_CYCLE: assert property (!vector_ready_strobe_n && !freeze |=> vector_ready_strobe_n)
      else $error("vector strobe longer than one cycle");
   AST_FREEZE_HOLD: assert property (freeze |=> $stable(vector_ready_strobe_n) && $stable(latency_strobe_n))
      else $error("strobes moved while frozen");
   AST_SHORT_LATENCY: assert property (disable iff (!rst_n_i || freeze || !chip_reset_n)
      short_start |-> ##102 !latency_strobe_n)
      else $error("8x8 latency strobe not on time");
   AST_TALL_LATENCY: assert property (disable iff (!rst_n_i || freeze || !chip_reset_n)
      tall_start |-> ##[302:302] !latency_strobe_n)
      else $error("16x16 latency strobe not on time");
   AST_RESET_FIRST: assert property (!block_start_strobe_n |-> reset_seen)
      else $error("block start before link reset");
   AST_STROBE_ONE_CYCLE: assert property (!block_start_strobe_n |=> block_start_strobe_n)
      else $error("block start longer than one cycle");
endmodule : msc_monitor

//--- verification/testbench.sv
// self-checking bench: controller and device joined by the link
// assumes one 10 MHz clock and an ahb-lite master driven here
`timescale 1ns/1ns
`define CHK(act, exp) \
   begin \
      n_tests++; \
      if ((act) !== (exp)) \
      begin \
         n_mismatch++; \
         $display("unexpected at %0t: got %0h expected %0h", $time, act, exp); \
      end \
   end
module testbench;
   import msc_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h00000000;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hreadyout;
   logic [3:0] edges;
   logic [15:0] scol;
   logic [15:0] vrange;
   logic werr;
   msc_size_type block_size;
   int n_mismatch = 0;
   int n_tests = 0;
   msc_link_if msc_link_if_inst ();
   assign edges = {msc_link_if_inst.left_edge_limit, msc_link_if_inst.bottom_edge_limit,
      msc_link_if_inst.right_edge_limit, msc_link_if_inst.top_edge_limit};
   msc_ctrl msc_ctrl_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
      .hresp_o(), .search_col_o(scol), .link(msc_link_if_inst));
   msc_device msc_device_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .link(msc_link_if_inst), .block_size_o(block_size), .h_lo_o(vrange[15:12]),
      .h_hi_o(vrange[11:8]), .v_lo_o(vrange[7:4]), .v_hi_o(vrange[3:0]),
      .upper_bands_o(), .width_error_o(werr));
   msc_monitor msc_monitor_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .chip_reset_n(msc_link_if_inst.chip_reset_n),
      .block_start_strobe_n(msc_link_if_inst.block_start_strobe_n),
      .tall_block_select(msc_link_if_inst.tall_block_select),
      .square_select_n(msc_link_if_inst.square_select_n),
      .freeze(msc_link_if_inst.freeze),
      .vector_ready_strobe_n(msc_link_if_inst.vector_ready_strobe_n),
      .latency_strobe_n(msc_link_if_inst.latency_strobe_n));
   // ======================================
   // bus and measurement tasks
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      @(posedge sys_clk_i);
      while (hreadyout !== 1'b1) @(posedge sys_clk_i);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge sys_clk_i);
      while (hreadyout !== 1'b1) @(posedge sys_clk_i);
      rd = hrdata;
   endtask : ahb
   task automatic measure(input int exp, input logic tl, input logic frz);
      int cnt;
      cnt = 0;
      do @(posedge sys_clk_i); while (msc_link_if_inst.block_start_strobe_n !== 1'b0);
      `CHK(msc_link_if_inst.tall_block_select, tl);
      fork
         do
         begin
            @(posedge sys_clk_i);
            if (msc_link_if_inst.freeze !== 1'b1) cnt++;
         end
         while (msc_link_if_inst.latency_strobe_n !== 1'b0 && cnt < 1000);
         if (frz)
         begin
            repeat (10) @(posedge sys_clk_i);
            ahb(1'b1, REG_CTRL, 32'h00000009);
            repeat (20) @(posedge sys_clk_i);
            ahb(1'b1, REG_CTRL, 32'h00000001);
         end
      join
      `CHK(cnt, exp);
      `CHK(msc_link_if_inst.vector_ready_strobe_n, 1'b0);
   endtask : measure
   // ======================================
   // scenarios
   task automatic test_regs();
      ahb(1'b0, REG_CTRL, 32'h0);
      `CHK(rd[4:0], CTRL_RESET_VAL);
      ahb(1'b0, REG_UNITS, 32'h0);
      `CHK(rd[7:0], UNITS_RESET_VAL);
      ahb(1'b0, 8'h1C, 32'h0);
      `CHK(rd, 32'h00000000);
      ahb(1'b1, REG_CLAMP, 32'h00000010);
      ahb(1'b0, REG_CLAMP, 32'h0);
      `CHK(rd[4:0], 5'h11);
      ahb(1'b1, REG_CLAMP, 32'h0000000F);
      ahb(1'b0, REG_CLAMP, 32'h0);
      `CHK(rd[4:0], 5'h0F);
   endtask : test_regs
   task automatic test_geometry();
      logic [3:0] tall = 4'b1100;
      logic [3:0] rect = 4'b1010;
      int units[4] = '{1, 3, 1, 2};
      int lat[4] = '{102, 134, 302, 174};
      for (int i = 0; i < 4; i++)
      begin
         ahb(1'b1, REG_UNITS, 32'(units[i]));
         ahb(1'b1, REG_CTRL, {29'h0, rect[i], tall[i], 1'b1});
         measure(lat[i], tall[i], 1'b0);
         `CHK(block_size, msc_size_type'({tall[i], rect[i]}));
         `CHK(werr, 1'b0);
         ahb(1'b1, REG_CTRL, 32'h0);
      end
   endtask : test_geometry
   task automatic test_freeze();
      ahb(1'b1, REG_CTRL, 32'h00000001);
      measure(102, 1'b0, 1'b1);
      ahb(1'b1, REG_CTRL, 32'h0);
   endtask : test_freeze
   task automatic test_edges();
      ahb(1'b1, REG_ROW, 32'h00000002);
      ahb(1'b1, REG_EDGE, 32'h00000005);
      ahb(1'b1, REG_CTRL, 32'h00000011);
      do @(posedge sys_clk_i); while (msc_link_if_inst.block_start_strobe_n !== 1'b0);
      `CHK(edges, EDGE_LEFT_ONLY);
      `CHK(scol, 16'(SEARCH_LEAD));
      repeat (64) @(posedge sys_clk_i);
      `CHK(edges, EDGE_RIGHT_ONLY);
      `CHK(scol, 16'(HEIGHT_SHORT + SEARCH_LEAD));
      `CHK(msc_link_if_inst.block_start_strobe_n, 1'b1);
      `CHK(vrange, {VEC_ZERO, VEC_HI, VEC_LO, VEC_HI});
      @(posedge sys_clk_i);
      `CHK(vrange, {VEC_LO, VEC_ZERO, VEC_LO, VEC_HI});
      ahb(1'b1, REG_CTRL, 32'h0);
   endtask : test_edges
   task report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   // ======================================
   // clock, watchdog, main sequence
   initial
   begin
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   initial
   begin
      #3000000;
      n_mismatch++;
      report_and_stop();
   end
   initial
   begin
      repeat (6) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      @(posedge sys_clk_i);
      test_regs();
      test_geometry();
      test_freeze();
      test_edges();
      report_and_stop();
   end
endmodule : testbench
